/* design/abx_alu.sv */
`timescale 1ns/1ps

// Pure arithmetic for one instruction; the caller registers whatever it uses.
module abx_alu
  import abx_pkg::*;
(
  input abx_pkg::abx_op_type op,
  input logic [abx_pkg::DATA_W-1:0] acc_value,
  input logic [abx_pkg::DATA_W-1:0] file_value,
  input logic carry_in,
  input logic [abx_pkg::BIT_W-1:0] bit_sel,
  output logic [abx_pkg::DATA_W-1:0] result,
  output abx_pkg::abx_flags_type flags,
  output logic bit_value
);

  // Carry into the sum: only the carry form feeds the old flag in.
  logic cin;
  // Nine-bit sum so the carry out of bit 7 is kept.
  logic [DATA_W:0] sum;
  // Five-bit low-nibble sum so the carry out of bit 3 is kept.
  logic [NIBBLE_W:0] low_sum;

  // The adder is shared by both add forms to keep one carry chain.
  always_comb begin
    cin = (op == ABX_OP_ADD_WITH_CARRY_TO_FILE) ? carry_in : 1'b0;
    sum = {1'b0, acc_value} + {1'b0, file_value} + {{DATA_W{1'b0}}, cin};
    low_sum = {1'b0, acc_value[NIBBLE_W-1:0]} + {1'b0, file_value[NIBBLE_W-1:0]} + {{NIBBLE_W{1'b0}}, cin};
  end

  // Result and flag selection per operation.
  always_comb begin
    result = file_value;
    flags.carry = carry_in;
    flags.half_carry_flag = 1'b0;
    flags.zero = 1'b0;
    bit_value = file_value[bit_sel];
    case (op)
      ABX_OP_ADD_ACCUMULATOR_TO_FILE, ABX_OP_ADD_WITH_CARRY_TO_FILE: begin
        // Both add forms report carry out of bit 7 and out of bit 3.
        result = sum[DATA_W-1:0];
        flags.carry = sum[DATA_W];
        flags.half_carry_flag = low_sum[NIBBLE_W];
        flags.zero = (sum[DATA_W-1:0] == DATA_RST);
      end
      ABX_OP_ARITHMETIC_SHIFT_RIGHT: begin
        // The sign bit is replicated, bit 0 falls into carry.
        result = {file_value[MSB_POS], file_value[DATA_W-1:1]};
        flags.carry = file_value[0];
        flags.zero = ({file_value[MSB_POS], file_value[DATA_W-1:1]} == DATA_RST);
      end
      ABX_OP_CLEAR_FILE_BIT: begin
        // Only the selected bit changes.
        result = file_value & ~(8'h01 << bit_sel);
      end
      default: begin
        // Other operations leave the data untouched.
        result = file_value;
      end
    endcase
  end

endmodule

/* design/abx_exec.sv */
`timescale 1ns/1ps

// Contract
// - Add accumulator and file, destination selectable.
// - Add with carry, destination selectable, flags.
// - Shift right keeping sign, bit 0 to carry.
// - Clear one file bit, flags untouched.
// - Bit clear skips next instruction, two cycles.
// - Jump target is incremented counter plus offset.
// - Relative jump always takes two cycles.
// - Counter change or true test: NOP second.
module abx_exec
  import abx_pkg::*;
#(
  parameter int PC_W = abx_pkg::PC_W_DEF
)
(
  input logic clock,
  input logic resetn,
  input logic issue_valid,
  input abx_pkg::abx_issue_type issue,
  input logic [abx_pkg::DATA_W-1:0] acc_value,
  input logic [abx_pkg::DATA_W-1:0] file_rdata,
  input logic carry_value,
  input logic [PC_W-1:0] pc_value,
  output logic acc_we_q,
  output logic [abx_pkg::DATA_W-1:0] acc_wdata_q,
  output logic file_we_q,
  output logic [abx_pkg::ADDR_W-1:0] file_waddr_q,
  output logic [abx_pkg::DATA_W-1:0] file_wdata_q,
  output logic flags_we_q,
  output logic half_we_q,
  output abx_pkg::abx_flags_type flags_q,
  output logic pc_load_q,
  output logic [PC_W-1:0] pc_target_q,
  output logic nop_slot_q
);

  // The offset is sign-extended into the counter, so the counter must be at least as wide.
  // The state machine keeps exactly one forced no-operation slot, so only long instructions
  // of two cycles can be served; any other figure is refused at elaboration.
  // Checking here rather than at run time keeps a bad setting out of any netlist.
  if ((PC_W < OFFS_W) || (LONG_CYCLES != 2)) begin : g_param_check
    $error("abx_exec: PC_W must cover the offset and LONG_CYCLES must be 2");
  end

  // Execution state: a normal cycle or the forced no-operation slot.
  // One slot state is enough because every long instruction costs exactly two cycles.
  typedef enum logic {
    ABX_ST_EXEC,
    ABX_ST_NOP
  } abx_state_type;

  abx_state_type state_q;
  abx_state_type state_d;

  // An instruction is accepted only outside the no-operation slot.
  logic take;
  // Combinational answers of the arithmetic unit.
  logic [DATA_W-1:0] alu_result;
  abx_flags_type alu_flags;
  logic alu_bit;
  // Flags which operation writes a data result and whether it is two cycles.
  logic writes_data;
  logic writes_flags;
  logic long_op;
  // Sign-extended jump target.
  logic [PC_W-1:0] jump_target;

  abx_alu u_alu (
    .op(issue.op),
    .acc_value(acc_value),
    .file_value(file_rdata),
    .carry_in(carry_value),
    .bit_sel(issue.bit_sel),
    .result(alu_result),
    .flags(alu_flags),
    .bit_value(alu_bit)
  );

  // Decode of the accepted instruction's side effects.
  // Results are only write requests that land one cycle late, so the core must forward
  // a result to a dependent instruction issued in the very next cycle.
  always_comb begin
    // The instruction fetched behind a long one is discarded, not executed.
    take = issue_valid && (state_q == ABX_ST_EXEC);
    writes_data = 1'b0;
    writes_flags = 1'b0;
    long_op = 1'b0;
    case (issue.op)
      ABX_OP_ADD_ACCUMULATOR_TO_FILE, ABX_OP_ADD_WITH_CARRY_TO_FILE, ABX_OP_ARITHMETIC_SHIFT_RIGHT: begin
        writes_data = 1'b1;
        writes_flags = 1'b1;
      end
      ABX_OP_CLEAR_FILE_BIT: begin
        // Data written back, status left alone.
        writes_data = 1'b1;
      end
      ABX_OP_SKIP_IF_BIT_CLEAR: begin
        // A zero bit makes the test true and costs the second cycle.
        long_op = ~alu_bit;
      end
      ABX_OP_RELATIVE_JUMP: begin
        // The jump costs two cycles whatever its offset.
        long_op = 1'b1;
      end
      default: begin
        long_op = 1'b0;
      end
    endcase
  end

  // The counter seen here has already been incremented past the jump, so adding the
  // offset gives the old address plus one plus the offset.
  // Wrap-around beyond the counter width is silent, as in the counter itself.
  // The offset is made signed first so that the cast extends its sign, not zeros.
  assign jump_target = pc_value + PC_W'($signed(issue.offset));

  // Next state: one cycle in the slot after each long instruction.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ABX_ST_EXEC: begin
        if (take && long_op) begin
          state_d = ABX_ST_NOP;
        end
      end
      ABX_ST_NOP: begin
        // The slot lasts exactly LONG_CYCLES - 1 cycles, which is one.
        state_d = ABX_ST_EXEC;
      end
      default: begin
        state_d = ABX_ST_EXEC;
      end
    endcase
  end

  // State register.
  // Reset returns to the normal state, so the first issue after release is taken.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ABX_ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // The slot marker is a registered copy so the core can discard its fetch.
  // It duplicates the state register on purpose, since outputs must come from a flip-flop.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nop_slot_q <= 1'b0;
    end else begin
      nop_slot_q <= take && long_op;
    end
  end

  // Accumulator write port: destination bit clear selects it.
  // A bit clear never goes here, whatever its destination bit says.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acc_we_q <= 1'b0;
      acc_wdata_q <= DATA_RST;
    end else begin
      acc_we_q <= take && writes_data && (issue.dest == DEST_ACC)
                  && (issue.op != ABX_OP_CLEAR_FILE_BIT);
      if (take) begin
        acc_wdata_q <= alu_result;
      end
    end
  end

  // File write port: destination bit set, or any bit clear, writes back.
  // The address is masked so that a decoder fault cannot reach beyond the file's range.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      file_we_q <= 1'b0;
      file_waddr_q <= ADDR_RST;
      file_wdata_q <= DATA_RST;
    end else begin
      file_we_q <= take && writes_data && ((issue.dest == DEST_FILE)
                   || (issue.op == ABX_OP_CLEAR_FILE_BIT));
      if (take) begin
        file_waddr_q <= issue.file_addr & ADDR_MAX;
        file_wdata_q <= alu_result;
      end
    end
  end

  // Status update: the shift does not touch the digit carry.
  // Carry and zero share one strobe; the digit carry has its own because only adds write it.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flags_we_q <= 1'b0;
      half_we_q <= 1'b0;
      flags_q <= FLAGS_RST;
    end else begin
      flags_we_q <= take && writes_flags;
      half_we_q <= take && writes_flags && (issue.op != ABX_OP_ARITHMETIC_SHIFT_RIGHT);
      if (take) begin
        flags_q <= alu_flags;
      end
    end
  end

  // Counter load: only the jump redirects the program counter.
  // The target is held between jumps; only the strobe says when it is fresh.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_load_q <= 1'b0;
      pc_target_q <= '0;
    end else begin
      pc_load_q <= take && (issue.op == ABX_OP_RELATIVE_JUMP);
      if (take && (issue.op == ABX_OP_RELATIVE_JUMP)) begin
        pc_target_q <= jump_target;
      end
    end
  end

endmodule

/* design/abx_pkg.sv */
package abx_pkg;

  // Width of the data path and of a file register address.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int OFFS_W = 9;

  // Width of the program counter at its documented size.
  localparam int PC_W_DEF = 15;

  // Highest file register address an instruction may name.
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;

  // Destination bit encodings.
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Bit positions used by the arithmetic: the sign bit and the digit boundary.
  localparam int MSB_POS = 7;
  localparam int NIBBLE_W = 4;

  // Reset values of the registered outputs.
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

  // Cycles taken by an instruction whose second cycle is a forced no-operation.
  localparam int LONG_CYCLES = 2;

  // Operations this execution slice carries out.
  typedef enum logic [2:0] {
    ABX_OP_NONE,
    ABX_OP_ADD_ACCUMULATOR_TO_FILE,
    ABX_OP_ADD_WITH_CARRY_TO_FILE,
    ABX_OP_ARITHMETIC_SHIFT_RIGHT,
    ABX_OP_CLEAR_FILE_BIT,
    ABX_OP_SKIP_IF_BIT_CLEAR,
    ABX_OP_RELATIVE_JUMP
  } abx_op_type;

  // One decoded instruction as handed over by the decoder.
  typedef struct packed {
    abx_op_type op;
    logic [ADDR_W-1:0] file_addr;
    logic dest;
    logic [BIT_W-1:0] bit_sel;
    logic signed [OFFS_W-1:0] offset;
  } abx_issue_type;

  // Status flags touched by this slice.
  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } abx_flags_type;

  localparam abx_flags_type FLAGS_RST = 3'h0;

endpackage

/* verif/abx_exec_monitor.sv */
`timescale 1ns/1ps

// Port-level watcher of the execution slice; helper registers keep the taken operands.
module abx_exec_monitor
  import abx_pkg::*;
#(parameter int PC_W = 15)
(
  input logic clock,
  input logic resetn,
  input logic issue_valid,
  input abx_issue_type issue,
  input logic [7:0] acc_value,
  input logic [7:0] file_rdata,
  input logic carry_value,
  input logic [PC_W-1:0] pc_value,
  input logic acc_we_q,
  input logic [7:0] acc_wdata_q,
  input logic file_we_q,
  input logic [6:0] file_waddr_q,
  input logic [7:0] file_wdata_q,
  input logic flags_we_q,
  input logic half_we_q,
  input abx_flags_type flags_q,
  input logic pc_load_q,
  input logic [PC_W-1:0] pc_target_q,
  input logic nop_slot_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // An issue offered in the slot cycle is not taken.
  wire logic tk = issue_valid && !nop_slot_q;
  wire logic cin = (issue.op == ABX_OP_ADD_WITH_CARRY_TO_FILE) && carry_value;
  wire logic add_w = tk && (issue.op == ABX_OP_ADD_ACCUMULATOR_TO_FILE || issue.op == ABX_OP_ADD_WITH_CARRY_TO_FILE);
  logic [8:0] sum_q;
  logic hc_q;
  logic [7:0] f_q;
  logic [2:0] b_q;
  logic d_q;
  logic [6:0] a_q;
  logic [PC_W-1:0] t_q;
  // Unreset on purpose: they are only read one cycle after a taken instruction.
  always_ff @(posedge clock) begin
    sum_q <= acc_value + file_rdata + cin;
    hc_q <= ({1'b0, acc_value[3:0]} + file_rdata[3:0] + cin) > 5'h0f;
    f_q <= file_rdata;
    b_q <= issue.bit_sel;
    d_q <= issue.dest;
    a_q <= issue.file_addr;
    t_q <= pc_value + {{(PC_W-9){issue.offset[8]}}, issue.offset};
  end
  AST_ADD: assert property (
    add_w |=> ((d_q ? file_wdata_q : acc_wdata_q) == sum_q[7:0])
      && (d_q ? (file_we_q && !acc_we_q && file_waddr_q == a_q) : (acc_we_q && !file_we_q)))
    else $error("add result or destination wrong");
  AST_ADD_FLAGS: assert property (
    add_w |=> flags_we_q && half_we_q && flags_q == {sum_q[8], hc_q, sum_q[7:0] == 8'h00})
    else $error("add flags wrong");
  AST_SHIFT: assert property (
    tk && issue.op == ABX_OP_ARITHMETIC_SHIFT_RIGHT |=> flags_we_q && !half_we_q
      && (d_q ? file_wdata_q : acc_wdata_q) == {f_q[7], f_q[7:1]}
      && flags_q.carry == f_q[0] && flags_q.zero == (f_q[7:1] == 7'h00))
    else $error("shift wrong");
  AST_CLEAR: assert property (
    tk && issue.op == ABX_OP_CLEAR_FILE_BIT |=> file_we_q && !flags_we_q && !half_we_q
      && file_waddr_q == a_q && file_wdata_q == (f_q & ~(8'h01 << b_q)))
    else $error("bit clear wrong");
  AST_SKIP: assert property (
    tk && issue.op == ABX_OP_SKIP_IF_BIT_CLEAR |=> nop_slot_q == !f_q[b_q]
      && !acc_we_q && !file_we_q && !flags_we_q && !pc_load_q)
    else $error("skip wrong");
  AST_JUMP: assert property (
    tk && issue.op == ABX_OP_RELATIVE_JUMP |=> pc_load_q && pc_target_q == t_q && !flags_we_q)
    else $error("jump target wrong");
  AST_JUMP_LEN: assert property (
    tk && issue.op == ABX_OP_RELATIVE_JUMP |=> nop_slot_q ##1 !nop_slot_q)
    else $error("jump not two cycles");
  AST_SLOT: assert property (
    nop_slot_q |=> !pc_load_q && !acc_we_q && !file_we_q && !flags_we_q)
    else $error("slot issue not discarded");
  AST_IDLE: assert property (
    !issue_valid |=> !acc_we_q && !file_we_q && !pc_load_q && !nop_slot_q)
    else $error("pulse without issue");
endmodule

/* verif/abx_exec_tb.sv */
`timescale 1ns/1ps

// Directed scenarios; each task drives one kind of instruction, the skip task also an empty one, and judges the answer.
module abx_exec_tb;
  import abx_pkg::*;
  localparam int PC_W = 15;
  logic clock, resetn, issue_valid, carry_value;
  abx_issue_type issue;
  logic [7:0] acc_value, file_rdata, acc_wdata_q, file_wdata_q;
  logic [PC_W-1:0] pc_value, pc_target_q;
  logic acc_we_q, file_we_q, flags_we_q, half_we_q, pc_load_q, nop_slot_q;
  logic [6:0] file_waddr_q;
  abx_flags_type flags_q;
  int failures, total_checks;
  abx_exec #(.PC_W(PC_W)) dut (.clock(clock), .resetn(resetn), .issue_valid(issue_valid), .issue(issue),
    .acc_value(acc_value), .file_rdata(file_rdata), .carry_value(carry_value), .pc_value(pc_value),
    .acc_we_q(acc_we_q), .acc_wdata_q(acc_wdata_q), .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
    .file_wdata_q(file_wdata_q), .flags_we_q(flags_we_q), .half_we_q(half_we_q), .flags_q(flags_q),
    .pc_load_q(pc_load_q), .pc_target_q(pc_target_q), .nop_slot_q(nop_slot_q));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  // Offers one instruction for one edge; hold keeps it offered into the next cycle.
  task send(input abx_op_type op, input logic [6:0] a, input logic d, input logic [2:0] b,
      input logic [8:0] o, input logic [7:0] w, input logic [7:0] f, input logic c, input logic hold);
    @(posedge clock);
    issue_valid <= 1'b1;
    issue <= '{op: op, file_addr: a, dest: d, bit_sel: b, offset: o};
    acc_value <= w;
    file_rdata <= f;
    carry_value <= c;
    @(posedge clock);
    issue_valid <= hold;
    #1;
  endtask
  task t_add(input abx_op_type op);
    logic [8:0] r;
    logic [7:0] w, f;
    logic h, cin, d;
    for (int i = 0; i < 8; i++) begin
      w = i[2] ? 8'hff : 8'h0f;
      f = i[1] ? 8'h00 : 8'h01;
      d = i[0] ^ i[1];
      cin = (op == ABX_OP_ADD_WITH_CARRY_TO_FILE) & i[0];
      r = w + f + cin;
      h = ({1'b0, w[3:0]} + f[3:0] + cin) > 5'h0f;
      send(op, ADDR_MAX ^ 7'(i), d, 3'h0, 9'h000, w, f, i[0], 1'b0);
      chk("dest_we", {!d, d}, {acc_we_q, file_we_q});
      chk("sum", r[7:0], d ? file_wdata_q : acc_wdata_q);
      if (d) chk("addr", ADDR_MAX ^ 7'(i), file_waddr_q);
      chk("flags", {2'b11, r[8], h, r[7:0] == 8'h00}, {flags_we_q, half_we_q, flags_q});
    end
    $display("add test done");
  endtask
  task t_shift;
    logic [7:0] f;
    for (int i = 0; i < 4; i++) begin
      f = (i == 0) ? 8'h81 : (i == 1) ? 8'h7e : (i == 2) ? 8'h01 : 8'h40;
      send(ABX_OP_ARITHMETIC_SHIFT_RIGHT, 7'h05, i[0], 3'h0, 9'h000, 8'h33, f, !f[0], 1'b0);
      chk("shift", {f[7], f[7:1]}, i[0] ? file_wdata_q : acc_wdata_q);
      chk("shift_we", {!i[0], i[0]}, {acc_we_q, file_we_q});
      chk("shift_flags", {2'b10, f[0], f[7:1] == 7'h00}, {flags_we_q, half_we_q, flags_q.carry, flags_q.zero});
    end
    $display("shift test done");
  endtask
  task t_clear;
    logic [7:0] f;
    for (int b = 0; b < 8; b++) begin
      f = b[0] ? 8'hff : 8'h5a;
      send(ABX_OP_CLEAR_FILE_BIT, 7'(b), DEST_ACC, 3'(b), 9'h000, 8'h00, f, 1'b0, 1'b0);
      chk("clear", f & ~(8'h01 << b), file_wdata_q);
      chk("clear_addr", 7'(b), file_waddr_q);
      chk("clear_we", 4'b1000, {file_we_q, acc_we_q, flags_we_q, half_we_q});
    end
    $display("clear test done");
  endtask
  task t_skip;
    logic [7:0] f;
    f = 8'h5a;
    for (int b = 0; b < 8; b++) begin
      send(ABX_OP_SKIP_IF_BIT_CLEAR, 7'h11, 1'b1, 3'(b), 9'h000, 8'h00, f, 1'b0, 1'b0);
      chk("skip", {!f[b], 4'h0}, {nop_slot_q, acc_we_q, file_we_q, flags_we_q, pc_load_q});
    end
    // An empty operation is taken but must request nothing.
    send(ABX_OP_NONE, 7'h11, 1'b1, 3'h0, 9'h000, 8'hff, 8'hff, 1'b1, 1'b0);
    chk("none", 5'h00, {nop_slot_q, acc_we_q, file_we_q, flags_we_q, pc_load_q});
    // A true skip held into its own slot is discarded there, so no second slot follows.
    send(ABX_OP_SKIP_IF_BIT_CLEAR, 7'h11, 1'b0, 3'h0, 9'h000, 8'h00, f, 1'b0, 1'b1);
    chk("skip_long", 1'b1, nop_slot_q);
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
    chk("skip_slot", 5'h00, {nop_slot_q, acc_we_q, file_we_q, flags_we_q, pc_load_q});
    $display("skip test done");
  endtask
  task t_jump;
    logic [8:0] o;
    logic [PC_W-1:0] pc, tgt;
    for (int i = 0; i < 3; i++) begin
      o = (i == 0) ? 9'h100 : (i == 1) ? 9'h0ff : 9'h1fe;
      pc = i[0] ? 15'h7f80 : 15'h0100;
      // The target wraps within the counter width, so the sum is kept at that width.
      tgt = pc + {{6{o[8]}}, o};
      @(posedge clock);
      pc_value <= pc;
      send(ABX_OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, o, 8'h00, 8'h00, 1'b1, 1'b1);
      chk("target", tgt, pc_target_q);
      chk("jump", 3'b110, {pc_load_q, nop_slot_q, flags_we_q});
      @(posedge clock);
      issue_valid <= 1'b0;
      #1;
      chk("slot", 4'h0, {pc_load_q, nop_slot_q, acc_we_q, file_we_q});
    end
    $display("jump test done");
  endtask
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    conclude();
  end
  initial begin
    resetn = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    acc_value = 8'h00;
    file_rdata = 8'h00;
    carry_value = 1'b0;
    pc_value = 15'h0000;
    failures = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    t_add(ABX_OP_ADD_ACCUMULATOR_TO_FILE);
    t_add(ABX_OP_ADD_WITH_CARRY_TO_FILE);
    t_shift();
    t_clear();
    t_skip();
    t_jump();
    conclude();
  end
endmodule

bind abx_exec abx_exec_monitor #(.PC_W(PC_W)) u_mon (.clock(clock), .resetn(resetn), .issue_valid(issue_valid),
  .issue(issue), .acc_value(acc_value), .file_rdata(file_rdata), .carry_value(carry_value), .pc_value(pc_value),
  .acc_we_q(acc_we_q), .acc_wdata_q(acc_wdata_q), .file_we_q(file_we_q), .file_waddr_q(file_waddr_q),
  .file_wdata_q(file_wdata_q), .flags_we_q(flags_we_q), .half_we_q(half_we_q), .flags_q(flags_q),
  .pc_load_q(pc_load_q), .pc_target_q(pc_target_q), .nop_slot_q(nop_slot_q));
